// *** switch_monitor_defines.svh ***
`ifndef SWITCH_MONITOR_DEFINES_SVH
`define SWITCH_MONITOR_DEFINES_SVH

// switch count and word geometry
`define NUM_SW 12
`define WORD_W 16
`define BITCNT_W 5
`define CMD_HI 15
`define CMD_LO 12

// command codes, top four bits of the command word
`define CMD_SLEEP 4'h0
`define CMD_RUN 4'h1
`define CMD_TRI 4'h3
`define CMD_METAL 4'h5

// field positions inside the run command
`define RUN_MODE_HI 11
`define RUN_MODE_LO 10
`define RUN_CP_HI 3
`define RUN_CP_LO 0

// response word layout
`define RSP_SW_HI 11
`define RSP_SW_LO 0
`define RSP_ROLE 12
`define RSP_INT 13
`define RSP_MODE_HI 15
`define RSP_MODE_LO 14

// mode field encodings
`define MODE_SLEEP 2'h0
`define MODE_NORMAL 2'h1
`define MODE_POLL 2'h2
`define MODE_POLLT 2'h3

// timing: mclk 20 MHz
`define MCLK_HZ 20000000
`define SUSTAIN_MS 20
`define SUSTAIN_CYC ((`MCLK_HZ / 1000) * `SUSTAIN_MS)
`define POLL_ON_CYC 16'h0100
`define POLL_OFF_CYC 16'h4000

`endif

// *** switch_monitor_pkg.sv ***
package switch_monitor_pkg;

    typedef enum logic [3:0]
    {
        ST_SLEEP = 4'b0001,
        ST_NORMAL = 4'b0010,
        ST_POLL_ON = 4'b0100,
        ST_POLL_OFF = 4'b1000
    } op_state_t;

    typedef logic [15:0] word_t;

endpackage

// *** wetting_timer.sv ***
`timescale 1ns/1ps
`include "switch_monitor_defines.svh"

module wetting_timer #(
    parameter int unsigned SUSTAIN_CYCLES = `SUSTAIN_CYC
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic enable,
    input wire logic closed,
    output logic highCurrent
);

    logic [19:0] count_reg;

    ////////////////////////////////////////////////////////////////
    // high pulse while closed, sustain after the timeout
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            count_reg <= 20'h00000;
        end
        else if (ce)
        begin
            if (!enable || !closed)
            begin
                count_reg <= 20'h00000;
            end
            else if (count_reg != SUSTAIN_CYCLES[19:0])
            begin
                count_reg <= count_reg + 20'h00001;
            end
        end
    end

    // open switch sits at sustain level until it closes
    assign highCurrent = enable && closed && (count_reg != SUSTAIN_CYCLES[19:0]);

endmodule // wetting_timer

// *** switch_monitor_serial_port.sv ***
`timescale 1ns/1ps
`include "switch_monitor_defines.svh"

// Behaviour
// - closed switch drops from pulse to sustain wetting current after 20 ms
// - response carries switch status, role, interrupt flag and mode
// - chained devices pass data through over 32 host clocks
// - command in and status out only while chip select low
// - select fall enables output, captures interrupt, mode and switches
// - select rise floats output, releases interrupt, applies command, resumes
// - serial input sampled into 16-bit shifter on rising serial clock
// - serial output advances on each falling serial clock
// - deselected: serial clock and input ignored, output floats
// - status bit is 0 for open, 1 for closed
// - select fall shows bit 15, each falling clock the next lower
// - both words travel msb first through one shift register
// - role select: master keeps oscillator, slave stops it between polls
// - master paces polls and wakes slaves; slave samples on wake
// - normal mode: any switch change asserts interrupt
// - interrupt flag is inverse of captured interrupt pin
// - polling: interrupt only during the poll on phase
// - reset clears state, floats switch inputs, enters sleep
// - sleep left only by a valid command word
// - command codes sleep, run, tri-state, metallic, test; others ignored
// - status reflects previous command, not the one shifting in
// - polling: a closed switch interrupts and returns to normal mode

module switch_monitor_serial_port
    import switch_monitor_pkg::*;
#(
    parameter int unsigned SUSTAIN_CYCLES = `SUSTAIN_CYC
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic resetIn_n,
    input wire logic chipSelect_n,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdo,
    output logic sdoOe,
    input wire logic [`NUM_SW-1:0] switchIn,
    input wire logic roleSelect,
    input wire logic wakeIn,
    output logic wakeOut,
    output logic oscRun,
    output logic irqOut_n,
    output logic irqOutOe,
    output logic [`NUM_SW-1:0] inputTristate,
    output logic [`NUM_SW-1:0] pulseCurrent,
    output logic [`NUM_SW-1:0] metallicSel,
    output logic testMode
);

    ////////////////////////////////////////////////////////////////
    // two-stage synchronisers for every pin input except roleSelect
    logic [4:0] syncA_reg;
    logic [4:0] syncB_reg;
    logic [`NUM_SW-1:0] swA_reg;
    logic [`NUM_SW-1:0] swB_reg;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            // idle pin levels, so no false wake or clock edge follows reset
            syncA_reg <= 5'h18;
            syncB_reg <= 5'h18;
            swA_reg <= '0;
            swB_reg <= '0;
        end
        else if (ce)
        begin
            syncA_reg <= {resetIn_n, chipSelect_n, sclk, sdi, wakeIn};
            syncB_reg <= syncA_reg;
            swA_reg <= switchIn;
            swB_reg <= swA_reg;
        end
    end

    logic resetS_n;
    logic csS_n;
    logic sclkS;
    logic sdiS;
    logic wakeS;
    assign {resetS_n, csS_n, sclkS, sdiS, wakeS} = syncB_reg;

    ////////////////////////////////////////////////////////////////
    // edge detection on synchronised select and serial clock
    logic csPrev_reg;
    logic sclkPrev_reg;
    logic wakePrev_reg;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            csPrev_reg <= 1'b1;
            sclkPrev_reg <= 1'b0;
            wakePrev_reg <= 1'b0;
        end
        else if (ce)
        begin
            csPrev_reg <= csS_n;
            sclkPrev_reg <= sclkS;
            wakePrev_reg <= wakeS;
        end
    end

    logic csFall;
    logic csRise;
    logic sclkRise;
    logic sclkFall;
    logic wakeRise;
    assign csFall = csPrev_reg && !csS_n;
    assign csRise = !csPrev_reg && csS_n;
    // clock edges count only while selected
    assign sclkRise = !csS_n && !csPrev_reg && sclkS && !sclkPrev_reg;
    assign sclkFall = !csS_n && !csPrev_reg && !sclkS && sclkPrev_reg;
    assign wakeRise = wakeS && !wakePrev_reg;

    ////////////////////////////////////////////////////////////////
    // configuration state, cleared by the reset pin
    op_state_t state_reg;
    logic [1:0] runMode_reg;
    logic [3:0] cpBattery_reg;
    logic [`NUM_SW-1:0] triCfg_reg;
    logic [`NUM_SW-1:0] metalCfg_reg;
    logic test_reg;
    logic irqAct_reg;
    logic [`NUM_SW-1:0] swLast_reg;

    logic sleeping;
    logic pollOn;
    logic sensing;
    assign sleeping = (state_reg == ST_SLEEP);
    assign pollOn = (state_reg == ST_POLL_ON);
    assign sensing = (state_reg == ST_NORMAL) || pollOn;

    // inputs arrive as closed=1; floated or unsensed inputs read open
    logic [`NUM_SW-1:0] closedNow;
    assign closedNow = sensing ? (swB_reg & ~triCfg_reg) : '0;

    ////////////////////////////////////////////////////////////////
    // one shift register for command in and status out
    word_t shift_reg;
    logic [`BITCNT_W-1:0] bitCnt_reg;
    logic sdo_reg;
    logic sdoOe_reg;
    word_t status;

    // mode 15:14, flag 13, role 12, switches 11:0
    always_comb
    begin
        status = '0;
        status[`RSP_SW_HI:`RSP_SW_LO] = closedNow;
        status[`RSP_ROLE] = roleSelect;
        status[`RSP_INT] = irqAct_reg;
        status[`RSP_MODE_HI:`RSP_MODE_LO] = sleeping ? `MODE_SLEEP : runMode_reg;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            shift_reg <= '0;
            bitCnt_reg <= '0;
            sdo_reg <= 1'b0;
            sdoOe_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (!resetS_n)
            begin
                shift_reg <= '0;
                bitCnt_reg <= '0;
                sdo_reg <= 1'b0;
                sdoOe_reg <= 1'b0;
            end
            else if (csFall)
            begin
                shift_reg <= status;
                sdo_reg <= status[`WORD_W-1];
                sdoOe_reg <= 1'b1;
                bitCnt_reg <= '0;
            end
            else if (csRise)
            begin
                sdoOe_reg <= 1'b0;
            end
            else if (sclkRise)
            begin
                // shifting through lets a chain pass words on
                shift_reg <= {shift_reg[`WORD_W-2:0], sdiS};
                // folds back to 16 so a chained 32-bit transfer still ends on a word
                bitCnt_reg <= (bitCnt_reg == 5'h1f) ? 5'h10 : bitCnt_reg + 5'h01;
            end
            else if (sclkFall)
            begin
                sdo_reg <= shift_reg[`WORD_W-1];
            end
        end
    end

    assign sdo = sdo_reg;
    assign sdoOe = sdoOe_reg;

    // a word counts only if a multiple of sixteen bits arrived
    logic cmdValid;
    logic [3:0] cmdCode;
    assign cmdValid = csRise && (bitCnt_reg[3:0] == 4'h0) && (bitCnt_reg != 5'h00);
    assign cmdCode = shift_reg[`CMD_HI:`CMD_LO];

    ////////////////////////////////////////////////////////////////
    // poll timing; a slave waits for the master's wake instead
    logic [15:0] pollCnt_reg;
    logic pollEnd;
    logic wakeNow;
    assign pollEnd = (pollCnt_reg == 16'h0000);
    assign wakeNow = roleSelect ? pollEnd : wakeRise;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pollCnt_reg <= '0;
        end
        else if (ce)
        begin
            if (!resetS_n || !(state_reg == ST_POLL_OFF || pollOn))
            begin
                pollCnt_reg <= '0;
            end
            else if (pollEnd)
            begin
                pollCnt_reg <= pollOn ? `POLL_OFF_CYC : `POLL_ON_CYC;
            end
            else
            begin
                pollCnt_reg <= pollCnt_reg - 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // operating state and command application
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= ST_SLEEP;
            runMode_reg <= `MODE_NORMAL;
            cpBattery_reg <= '0;
            triCfg_reg <= '0;
            metalCfg_reg <= '0;
            test_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (!resetS_n)
            begin
                state_reg <= ST_SLEEP;
                runMode_reg <= `MODE_NORMAL;
                cpBattery_reg <= '0;
                triCfg_reg <= '0;
                metalCfg_reg <= '0;
                test_reg <= 1'b0;
            end
            else if (cmdValid)
            begin
                if (cmdCode[3])
                begin
                    test_reg <= 1'b1;
                end
                else if (cmdCode == `CMD_SLEEP)
                begin
                    state_reg <= ST_SLEEP;
                end
                else if (cmdCode == `CMD_RUN)
                begin
                    runMode_reg <= shift_reg[`RUN_MODE_HI:`RUN_MODE_LO];
                    cpBattery_reg <= shift_reg[`RUN_CP_HI:`RUN_CP_LO];
                    state_reg <= (shift_reg[`RUN_MODE_HI:`RUN_MODE_LO] == `MODE_POLL ||
                                  shift_reg[`RUN_MODE_HI:`RUN_MODE_LO] == `MODE_POLLT) ? ST_POLL_OFF : ST_NORMAL;
                end
                else if (cmdCode == `CMD_TRI)
                begin
                    triCfg_reg <= shift_reg[`NUM_SW-1:0];
                    state_reg <= sleeping ? ST_NORMAL : state_reg;
                end
                else if (cmdCode == `CMD_METAL)
                begin
                    metalCfg_reg <= shift_reg[`NUM_SW-1:0];
                    state_reg <= sleeping ? ST_NORMAL : state_reg;
                end
            end
            else
            begin
                case (state_reg)
                    ST_POLL_OFF:
                    begin
                        if (wakeNow)
                        begin
                            state_reg <= ST_POLL_ON;
                        end
                    end
                    ST_POLL_ON:
                    begin
                        if (|closedNow)
                        begin
                            state_reg <= ST_NORMAL;
                            runMode_reg <= `MODE_NORMAL;
                        end
                        else if (roleSelect && pollEnd)
                        begin
                            state_reg <= ST_POLL_OFF;
                        end
                        else if (!roleSelect && !wakeS)
                        begin
                            state_reg <= ST_POLL_OFF;
                        end
                    end
                    default:
                    begin
                        state_reg <= state_reg;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // interrupt: change in normal, closure in the poll on phase
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            irqAct_reg <= 1'b0;
            swLast_reg <= '0;
        end
        else if (ce)
        begin
            swLast_reg <= closedNow;
            if (!resetS_n)
            begin
                irqAct_reg <= 1'b0;
            end
            else if (state_reg == ST_NORMAL && closedNow != swLast_reg)
            begin
                irqAct_reg <= 1'b1;
            end
            else if (pollOn && |closedNow)
            begin
                irqAct_reg <= 1'b1;
            end
            else if (csRise)
            begin
                irqAct_reg <= 1'b0;
            end
        end
    end

    // open drain: drive low only when asserted
    assign irqOut_n = 1'b0;
    assign irqOutOe = irqAct_reg;

    ////////////////////////////////////////////////////////////////
    // oscillator, wake output and per-input current control
    assign oscRun = !sleeping && (roleSelect || state_reg != ST_POLL_OFF);
    assign wakeOut = roleSelect && pollOn;
    assign inputTristate = (sleeping || state_reg == ST_POLL_OFF) ? '1 : triCfg_reg;
    assign metallicSel = metalCfg_reg;
    assign testMode = test_reg;

    genvar gi;
    generate
        for (gi = 0; gi < `NUM_SW; gi++)
        begin : g_wet
            wetting_timer #(
                .SUSTAIN_CYCLES(SUSTAIN_CYCLES)
            ) u_wet (
                .mclk(mclk),
                .rst(rst),
                .ce(ce),
                .enable(sensing && !triCfg_reg[gi]),
                .closed(closedNow[gi]),
                .highCurrent(pulseCurrent[gi])
            );
        end
    endgenerate

endmodule // switch_monitor_serial_port

// *** switch_monitor_serial_port_checker.sv ***
`timescale 1ns/1ps
`include "switch_monitor_defines.svh"

module switch_monitor_serial_port_checker
#(
    parameter int unsigned SUSTAIN_CYCLES = `SUSTAIN_CYC
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic resetIn_n,
    input wire logic chipSelect_n,
    input wire logic sclk,
    input wire logic sdo,
    input wire logic sdoOe,
    input wire logic roleSelect,
    input wire logic wakeOut,
    input wire logic irqOutOe,
    input wire logic [`NUM_SW-1:0] inputTristate,
    input wire logic [`NUM_SW-1:0] pulseCurrent,
    input wire logic testMode
);
    int unsigned pulseCnt;

    // length of the high current pulse on input 0, too long for a repetition
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            pulseCnt <= 0;
        else if (pulseCurrent[0])
            pulseCnt <= pulseCnt + 1;
        else
            pulseCnt <= 0;
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // margins cover the two stage synchroniser and the edge detector
    a_deselect_floats: assert property (chipSelect_n [*6] |-> !sdoOe) else $error("sdo driven while deselected");
    a_select_drives: assert property ($fell(chipSelect_n) |-> ##[2:5] sdoOe) else $error("sdo not enabled");
    a_rise_floats: assert property ($rose(chipSelect_n) |-> ##[2:5] !sdoOe) else $error("sdo not floated");
    a_rise_clears_irq: assert property ($rose(chipSelect_n) |-> ##[2:5] !irqOutOe) else $error("irq kept");
    a_reset_sleeps: assert property (!resetIn_n [*5] |-> (&inputTristate) && !testMode) else $error("no sleep");
    a_sdo_on_fall: assert property ((!chipSelect_n && sclk) [*4] |-> $stable(sdo)) else $error("sdo moved");
    a_wake_master: assert property (wakeOut |-> roleSelect) else $error("slave drove wake");
    a_pulse_bounded: assert property (pulseCnt <= SUSTAIN_CYCLES + 8) else $error("pulse too long");
    a_float_no_current: assert property ((inputTristate & pulseCurrent) == '0) else $error("current on float");

    // main scenarios reached
    c_frame: cover property ($fell(chipSelect_n));
    c_wake: cover property ($rose(wakeOut));
    c_irq: cover property ($rose(irqOutOe));
    c_pulse_end: cover property ($fell(pulseCurrent[0]));
endmodule // switch_monitor_serial_port_checker

bind switch_monitor_serial_port switch_monitor_serial_port_checker #(.SUSTAIN_CYCLES(SUSTAIN_CYCLES)) i_checker
(
    .mclk(mclk), .rst(rst), .resetIn_n(resetIn_n), .chipSelect_n(chipSelect_n), .sclk(sclk), .sdo(sdo),
    .sdoOe(sdoOe), .roleSelect(roleSelect), .wakeOut(wakeOut), .irqOutOe(irqOutOe),
    .inputTristate(inputTristate), .pulseCurrent(pulseCurrent), .testMode(testMode)
);

// *** spi_host_model.sv ***
`timescale 1ns/1ps

module spi_host_model
(
    input wire logic mclk,
    input wire logic sdo,
    input wire logic sdoOe,
    output logic chipSelect_n,
    output logic sclk,
    output logic sdi
);
    // idle: select pulled up, clock parked low, data pulled down
    initial
    begin
        chipSelect_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one framed transfer of n bits, msb first; half sets the pace, larger is a slow host
    task automatic xfer(input logic [31:0] tx, input int n, input int half, output logic [31:0] rx);
        rx = '0;
        @(negedge mclk);
        chipSelect_n = 1'b0;
        repeat (2 * half) @(negedge mclk);
        for (int i = n - 1; i >= 0; i--)
        begin
            sdi = tx[i];
            repeat (half) @(negedge mclk);
            sclk = 1'b1;
            repeat (half) @(negedge mclk);
            // sampled late in the high phase; an undriven line reads as the wrong bit
            rx = {rx[30:0], sdoOe ? sdo : !sdo};
            sclk = 1'b0;
        end
        repeat (half) @(negedge mclk);
        chipSelect_n = 1'b1;
        sdi = 1'b0;
        repeat (2 * half) @(negedge mclk);
    endtask
endmodule // spi_host_model

// *** switch_monitor_serial_port_tb_top.sv ***
`timescale 1ns/1ps
`include "switch_monitor_defines.svh"

module switch_monitor_serial_port_tb_top;
    import switch_monitor_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic resetIn_n = 1'b1;
    logic roleSelect = 1'b1;
    logic wakeIn = 1'b0;
    logic [11:0] switchIn = '0;
    logic chipSelect_n, sclk, sdi, sdo, sdoOe, wakeOut, oscRun, irqOut_n, irqOutOe, testMode;
    logic [11:0] inputTristate, pulseCurrent, metallicSel, triM;
    logic [31:0] rx;
    logic [31:0] seed = 32'hf9b8;
    int failures = 0;
    int tests_run = 0;
    int modeM = 0;
    logic flagM = 1'b0;

    always #25 mclk = ~mclk;

    switch_monitor_serial_port #(.SUSTAIN_CYCLES(50)) i_switch_monitor_serial_port
    (
        .mclk(mclk), .rst(rst), .ce(1'b1), .resetIn_n(resetIn_n), .chipSelect_n(chipSelect_n), .sclk(sclk),
        .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe), .switchIn(switchIn), .roleSelect(roleSelect), .wakeIn(wakeIn),
        .wakeOut(wakeOut), .oscRun(oscRun), .irqOut_n(irqOut_n), .irqOutOe(irqOutOe),
        .inputTristate(inputTristate), .pulseCurrent(pulseCurrent), .metallicSel(metallicSel), .testMode(testMode)
    );
    spi_host_model i_spi_host_model
    (
        .mclk(mclk), .sdo(sdo), .sdoOe(sdoOe), .chipSelect_n(chipSelect_n), .sclk(sclk), .sdi(sdi)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic waitHigh(ref logic s, input int lim);
        for (int t = 0; t < lim && s !== 1'b1; t++)
            @(negedge mclk);
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // model status word: floated inputs read open
    function automatic logic [31:0] status();
        return {16'h0, modeM[1:0], flagM, roleSelect, switchIn & ~(modeM == 0 ? 12'hfff : triM)};
    endfunction

    // one command frame; status must reflect the model before this command
    task automatic frame(input logic [15:0] cmd, input int half);
        int was;
        was = modeM;
        i_spi_host_model.xfer({16'h0, cmd}, 16, half, rx);
        chk("status", status(), rx);
        case (cmd[15:12])
            4'h0: modeM = 0;
            4'h1: modeM = cmd[11:10];
            4'h3:
            begin
                triM = cmd[11:0];
                modeM = (modeM == 0) ? 1 : modeM;
            end
            4'h5: modeM = (modeM == 0) ? 1 : modeM;
            default: ;
        endcase
        // leaving sleep into normal with a closed input reads as a change
        flagM = (was == 0) && (modeM == 1) && (|(switchIn & ~triM));
        chk("irq", flagM, irqOutOe);
    endtask

    // change the switches at the falling edge; expect an interrupt only if they differ
    task automatic setSw(input logic [11:0] v);
        flagM = (v != switchIn);
        @(negedge mclk) switchIn = v;
        repeat (40) @(negedge mclk);
        chk("irq", flagM, irqOutOe);
        chk("irq pin", !flagM, irqOutOe ? irqOut_n : 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // watchdog sized well above the two poll waits
    initial
    begin
        repeat (90000) @(posedge mclk);
        failures++;
        conclude();
    end

    initial
    begin
        triM = '0;
        repeat (6) @(posedge mclk);
        @(negedge mclk) rst = 1'b0;
        chk("float", 12'hfff, inputTristate);
        repeat (3) @(negedge mclk);
        i_spi_host_model.xfer(32'h1400, 15, 4, rx);
        chk("short", status() >> 1, rx);
        frame(16'h2400, 4);
        frame(16'h1400, 4);
        setSw(12'h001);
        chk("pulse", 1, pulseCurrent[0]);
        repeat (60) @(negedge mclk);
        chk("sustain", 0, pulseCurrent[0]);
        frame(16'h1400, 5);
        for (int k = 0; k < 4; k++)
        begin
            seed = lfsr(seed);
            setSw(seed[11:0]);
            frame(16'h1400, 4 + k);
        end
        i_spi_host_model.xfer({16'h0abc, 16'h1400}, 32, 4, rx);
        chk("chain", {status(), 16'h0abc}, rx);
        setSw(12'h000);
        frame(16'h3a5a, 4);
        chk("tristate", 12'ha5a, inputTristate);
        frame(16'h55c3, 4);
        chk("metallic", 12'h5c3, metallicSel);
        frame(16'h3000, 4);
        @(negedge mclk) roleSelect = 1'b0;
        frame(16'h1800, 4);
        repeat (100) @(negedge mclk);
        chk("slave osc", 0, oscRun);
        @(negedge mclk) wakeIn = 1'b1;
        waitHigh(oscRun, 20);
        chk("slave wake", 1, oscRun);
        @(negedge mclk) wakeIn = 1'b0;
        roleSelect = 1'b1;
        repeat (20) @(negedge mclk);
        chk("master osc", 1, oscRun);
        waitHigh(wakeOut, 20000);
        chk("wake", 1, wakeOut);
        @(negedge mclk) switchIn = 12'h004;
        waitHigh(irqOutOe, 20000);
        chk("poll irq", 1, irqOutOe);
        modeM = 1;
        flagM = 1'b1;
        frame(16'h0000, 4);
        frame(16'h1400, 4);
        frame(16'h8000, 4);
        chk("test", 1, testMode);
        @(negedge mclk) resetIn_n = 1'b0;
        repeat (6) @(negedge mclk);
        resetIn_n = 1'b1;
        modeM = 0;
        triM = '0;
        chk("reset float", 12'hfff, inputTristate);
        repeat (3) @(negedge mclk);
        frame(16'h1400, 4);
        @(negedge mclk) rst = 1'b1;
        @(negedge mclk) rst = 1'b0;
        chk("rst sdoOe", 0, sdoOe);
        conclude();
    end
endmodule // switch_monitor_serial_port_tb_top
